// *** hw/sllset_link_setup.sv ***
`timescale 1ns/1ps
// Operation
// RL1: PLL status bit 0 reads 1 once the serdes PLL locks after enable.
// RL2: In subclass 1 the transmitter sends at least one SYSREF edge after arming.
// RL3: Sync status bit 3 reads 1 after SYSREF and multiframe clock alignment.
// RL4: Link control bit 2 picks which link's status is read back.
// RL5: Each logical lane with its inversion bit set is inverted.
// RL6: Link enable field is 3 in dual-link mode, 1 in single-link mode.
// RL7: Physical lanes map to logical lanes through the crossbar registers.
// RL8: Sync control written 0x01, then 0x81, then 0xc1 before SYSREF.
// RL9: Transmitter uses the same link parameters that are programmed here; the tx model takes no link parameters and passes laneData straight through.
module sllset_link_setup
    import sllset_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire sllset_pkg::sllset_req_t hostReq,
    output sllset_pkg::sllset_rsp_t   hostRsp,
    input  wire logic                 pllEnable,
    input  wire logic                 sysrefPin,
    input  wire logic [7:0]           physLanesPin,
    input  wire logic [1:0]           linkSyncedPin,
    output logic [LANES-1:0]          logLanes,
    output logic [1:0]                linkEnables,
    output logic                      syncLockedOut,
    output logic                      pllLockedOut
);
    import sllset_pkg::*;

    logic [7:0]  syncCtrl_r;
    logic [7:0]  linkCtrl_r;
    logic [7:0]  subclass_r;
    logic [7:0]  mfDel_r [2];
    logic [7:0]  mfVar_r [2];
    logic [7:0]  xbar_r [XBAR_REGS];
    logic [7:0]  polInv_r;
    sllset_rsp_t rsp_r;
    logic [7:0]  rdVal;
    logic [1:0]  sysrefSync_r;
    logic        sysrefPrev_r;
    logic [7:0]  laneMeta_r;
    logic [7:0]  laneSync_r;
    logic [1:0]  linkMeta_r;
    logic [1:0]  linkSync_r;
    logic [1:0]  pllEnSync_r;
    logic [7:0]  pllCnt_r;
    logic        pllLock_r;
    logic        syncLocked;
    logic        sysrefEdge;
    logic [LANES-1:0] logLanes_nxt;
    logic [LANES-1:0] logLanes_r;
    logic [23:0] xbarFlat;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sysrefSync_r <= 2'h0;
            sysrefPrev_r <= 1'b0;
            laneMeta_r   <= 8'h00;
            laneSync_r   <= 8'h00;
            linkMeta_r   <= 2'h0;
            linkSync_r   <= 2'h0;
            pllEnSync_r  <= 2'h0;
        end else begin
            sysrefSync_r <= {sysrefSync_r[0], sysrefPin};
            sysrefPrev_r <= sysrefSync_r[1];
            laneMeta_r   <= physLanesPin;
            laneSync_r   <= laneMeta_r;
            linkMeta_r   <= linkSyncedPin;
            linkSync_r   <= linkMeta_r;
            pllEnSync_r  <= {pllEnSync_r[0], pllEnable};
        end
    end

    assign sysrefEdge = sysrefSync_r[1] & ~sysrefPrev_r;

    // The PLL model counts a fixed lock time after enable.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pllCnt_r  <= 8'h00;
            pllLock_r <= 1'b0;
        end else if (!pllEnSync_r[1]) begin
            pllCnt_r  <= 8'h00;
            pllLock_r <= 1'b0;
        end else if (pllCnt_r == 8'(PLL_LOCK_CYC - 1)) begin
            pllLock_r <= 1'b1; // RL1
        end else begin
            pllCnt_r <= pllCnt_r + 8'h01;
        end
    end

    // Register writes from the host serial port.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            syncCtrl_r <= RST_REG;
            linkCtrl_r <= RST_REG;
            subclass_r <= RST_REG;
            mfDel_r    <= '{RST_REG, RST_REG};
            mfVar_r    <= '{RST_REG, RST_REG};
            xbar_r     <= '{RST_XBAR0, RST_XBAR1, RST_XBAR2, RST_XBAR3};
            polInv_r   <= RST_REG;
        end else if (hostReq.wrEn) begin
            if (hostReq.addr == OFF_SYNC_CTRL) begin
                syncCtrl_r <= hostReq.wdata; // RL8
            end else if (hostReq.addr == OFF_LINK_CTRL) begin
                linkCtrl_r <= hostReq.wdata;
            end else if (hostReq.addr == OFF_SUBCLASS) begin
                subclass_r <= hostReq.wdata;
            end else if (hostReq.addr == OFF_MFDEL0) begin
                mfDel_r[0] <= hostReq.wdata;
            end else if (hostReq.addr == OFF_MFDEL1) begin
                mfDel_r[1] <= hostReq.wdata;
            end else if (hostReq.addr == OFF_MFVAR0) begin
                mfVar_r[0] <= hostReq.wdata;
            end else if (hostReq.addr == OFF_MFVAR1) begin
                mfVar_r[1] <= hostReq.wdata;
            end else if (hostReq.addr >= OFF_XBAR_FIRST && hostReq.addr <= OFF_XBAR_LAST) begin
                xbar_r[2'(hostReq.addr - OFF_XBAR_FIRST)] <= hostReq.wdata; // RL7
            end else if (hostReq.addr == OFF_POL_INV) begin
                polInv_r <= hostReq.wdata; // RL5
            end
        end
    end

    sllset_sync_fsm u_sync (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .syncEnable (syncCtrl_r[BIT_SYNC_ENABLE]),
        .syncArm    (syncCtrl_r[BIT_SYNC_ARM]),
        .sysrefEdge (sysrefEdge),
        .syncLocked (syncLocked)
    );

    // Each crossbar byte holds two 3-bit logical lane selects.
    always_comb begin
        for (int i = 0; i < XBAR_REGS; i++) begin
            xbarFlat[6*i +: 6] = xbar_r[i][5:0];
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : gLane
        sllset_lane_map u_map (
            .physLanes (laneSync_r),
            .selIdx    (xbarFlat[3*g +: 3]),
            .invert    (polInv_r[g]),
            .logLane   (logLanes_nxt[g])
        );
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            logLanes_r <= 8'h00;
        end else begin
            logLanes_r <= logLanes_nxt; // RL5 RL7
        end
    end

    // Read mux; the OFF_MFDEL0 and OFF_MFVAR0 reads follow the link chosen by the status select bit.
    always_comb begin
        rdVal = 8'h00;
        if (hostReq.addr == OFF_SYNC_CTRL) begin
            rdVal = syncCtrl_r;
        end else if (hostReq.addr == OFF_SYNC_STAT) begin
            rdVal = 8'(syncLocked) << BIT_SYNC_LOCK; // RL3
        end else if (hostReq.addr == OFF_PLL_STAT) begin
            rdVal = {7'h00, pllLock_r}; // RL1
        end else if (hostReq.addr == OFF_LINK_CTRL) begin
            rdVal = linkCtrl_r;
        end else if (hostReq.addr == OFF_SUBCLASS) begin
            rdVal = subclass_r;
        end else if (hostReq.addr == OFF_MFDEL0) begin
            rdVal = mfDel_r[linkCtrl_r[BIT_STATUS_LINK]]; // RL4
        end else if (hostReq.addr == OFF_MFDEL1) begin
            rdVal = mfDel_r[1];
        end else if (hostReq.addr == OFF_MFVAR0) begin
            rdVal = mfVar_r[linkCtrl_r[BIT_STATUS_LINK]]; // RL4
        end else if (hostReq.addr == OFF_MFVAR1) begin
            rdVal = mfVar_r[1];
        end else if (hostReq.addr >= OFF_XBAR_FIRST && hostReq.addr <= OFF_XBAR_LAST) begin
            rdVal = xbar_r[2'(hostReq.addr - OFF_XBAR_FIRST)];
        end else if (hostReq.addr == OFF_POL_INV) begin
            rdVal = polInv_r;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= hostReq.rdEn;
            rsp_r.rdata <= hostReq.rdEn ? rdVal : 8'h00;
        end
    end

    assign hostRsp       = rsp_r;
    assign logLanes      = logLanes_r;
    assign syncLockedOut = syncLocked;
    assign pllLockedOut  = pllLock_r;

    // Links only come up with the documented enable codes.
    always_comb begin
        linkEnables = 2'h0;
        if (linkCtrl_r[BIT_TWO_LINK] && linkCtrl_r[1:0] == LINK_EN_DUAL) begin
            linkEnables = LINK_EN_DUAL; // RL6
        end else if (!linkCtrl_r[BIT_TWO_LINK] && linkCtrl_r[1:0] == LINK_EN_SINGLE) begin
            linkEnables = LINK_EN_SINGLE; // RL6
        end
    end

    // Checks on the PLL lock flag and its readback.
    pll_lock_time_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
        $rose(pllLock_r) |->
        $past(pllEnSync_r[1]) && $past(pllCnt_r) == 8'(PLL_LOCK_CYC - 1))
        else $error("PLL lock flag rose early.");

    pll_drop_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
        !pllEnSync_r[1] |=> !pllLock_r)
        else $error("PLL lock held while disabled.");

    pll_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
        pllLock_r && pllEnSync_r[1] |=> pllLock_r)
        else $error("PLL lock dropped while enabled.");

    pll_stat_read_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
        hostReq.rdEn && hostReq.addr == OFF_PLL_STAT |=>
        hostRsp.valid && hostRsp.rdata == {7'h00, $past(pllLock_r)})
        else $error("PLL status readback wrong.");

    // Checks on the sync machine, its control and its status.
    sync_stat_read_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
        hostReq.rdEn && hostReq.addr == OFF_SYNC_STAT |=>
        hostRsp.valid && hostRsp.rdata[BIT_SYNC_LOCK] == $past(syncLocked))
        else $error("Sync status readback wrong.");

    sync_drop_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
        !syncCtrl_r[BIT_SYNC_ENABLE] |=> !syncLocked)
        else $error("Sync lock held while disabled.");

    sync_lock_edge_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
        $rose(syncLocked) |-> $past(sysrefEdge, ALIGN_CYC + 1))
        else $error("Sync lock without a SYSREF edge.");

    sysref_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
        sysrefEdge |=> !sysrefEdge)
        else $error("SYSREF edge lasted more than one cycle.");

    sync_enable_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL8
        syncLocked |-> $past(syncCtrl_r[BIT_SYNC_ENABLE]))
        else $error("Sync lock without enable.");

    sync_ctrl_write_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL8
        hostReq.wrEn && hostReq.addr == OFF_SYNC_CTRL |=> syncCtrl_r == $past(hostReq.wdata))
        else $error("Sync control write lost.");

    // Checks on the lane crossbar and inversion.
    lane_invert_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL5
        ##1 logLanes_r[0] == ($past(laneSync_r[xbar_r[0][2:0]]) ^ $past(polInv_r[0])))
        else $error("Lane zero map or inversion wrong.");

    lane_seven_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
        ##1 logLanes_r[7] == ($past(laneSync_r[xbar_r[3][5:3]]) ^ $past(polInv_r[7])))
        else $error("Lane seven map or inversion wrong.");

    pol_inv_write_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL5
        hostReq.wrEn && hostReq.addr == OFF_POL_INV |=> polInv_r == $past(hostReq.wdata))
        else $error("Polarity write lost.");

    xbar_write_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
        hostReq.wrEn && hostReq.addr == OFF_XBAR_FIRST |=> xbar_r[0] == $past(hostReq.wdata))
        else $error("Crossbar write lost.");

    xbar_last_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
        hostReq.wrEn && hostReq.addr == OFF_XBAR_LAST |=> xbar_r[3] == $past(hostReq.wdata))
        else $error("Last crossbar write lost.");

    // Checks on link enables and the status link select.
    link_enable_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
        linkEnables != 2'h0 |-> linkEnables == (linkCtrl_r[BIT_TWO_LINK] ? 2'h3 : 2'h1))
        else $error("Link enable code mismatch.");

    dual_enable_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
        linkCtrl_r[BIT_TWO_LINK] && linkCtrl_r[1:0] == LINK_EN_DUAL |->
        linkEnables == LINK_EN_DUAL)
        else $error("Dual link enables missing.");

    single_enable_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
        !linkCtrl_r[BIT_TWO_LINK] && linkCtrl_r[1:0] == LINK_EN_SINGLE |->
        linkEnables == LINK_EN_SINGLE)
        else $error("Single link enable missing.");

    status_select_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL4
        hostReq.rdEn && hostReq.addr == OFF_MFDEL0 |=>
        hostRsp.rdata == $past(mfDel_r[linkCtrl_r[BIT_STATUS_LINK]]))
        else $error("Status link select ignored.");

    var_select_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL4
        hostReq.rdEn && hostReq.addr == OFF_MFVAR0 |=>
        hostRsp.rdata == ($past(linkCtrl_r[BIT_STATUS_LINK]) ?
                          $past(mfVar_r[1]) : $past(mfVar_r[0])))
        else $error("Variable delay link select ignored.");

    // Link sync status is sampled but no register shows it.
    logic unusedLink;
    assign unusedLink = ^linkSync_r;
endmodule : sllset_link_setup

// *** hw/sllset_pkg.sv ***
package sllset_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int LANES  = 8;
    localparam int XBAR_REGS = 4;

    localparam logic [11:0] OFF_SYNC_CTRL   = 12'h03a;
    localparam logic [11:0] OFF_SYNC_STAT   = 12'h03b;
    localparam logic [11:0] OFF_PLL_STAT    = 12'h281;
    localparam logic [11:0] OFF_LINK_CTRL   = 12'h300;
    localparam logic [11:0] OFF_SUBCLASS    = 12'h301;
    localparam logic [11:0] OFF_MFDEL0      = 12'h304;
    localparam logic [11:0] OFF_MFDEL1      = 12'h305;
    localparam logic [11:0] OFF_MFVAR0      = 12'h306;
    localparam logic [11:0] OFF_MFVAR1      = 12'h307;
    localparam logic [11:0] OFF_XBAR_FIRST  = 12'h308;
    localparam logic [11:0] OFF_XBAR_LAST   = 12'h30b;
    localparam logic [11:0] OFF_POL_INV     = 12'h334;

    localparam int BIT_PLL_LOCK      = 0;
    localparam int BIT_SYNC_LOCK     = 3;
    localparam int BIT_SYNC_ENABLE   = 7;
    localparam int BIT_SYNC_ARM      = 6;
    localparam int BIT_CHECKSUM      = 6;
    localparam int BIT_TWO_LINK      = 3;
    localparam int BIT_STATUS_LINK   = 2;
    localparam int LINK_EN_LSB       = 0;
    localparam int SYNC_MODE_LSB     = 0;

    localparam logic [1:0] LINK_EN_DUAL   = 2'h3;
    localparam logic [1:0] LINK_EN_SINGLE = 2'h1;
    localparam logic [1:0] SYNC_ONE_SHOT  = 2'h1;

    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [7:0] RST_XBAR0   = 8'h08;
    localparam logic [7:0] RST_XBAR1   = 8'h1a;
    localparam logic [7:0] RST_XBAR2   = 8'h2c;
    localparam logic [7:0] RST_XBAR3   = 8'h3e;

    localparam int PLL_LOCK_NS   = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PLL_LOCK_CYC  = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALIGN_CYC     = 4;

    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sllset_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } sllset_rsp_t;

    typedef enum logic [1:0] {SYNC_IDLE, SYNC_ARMED, SYNC_ALIGN, SYNC_LOCKED} sllset_sync_t;

endpackage : sllset_pkg

// *** hw/sllset_lane_map.sv ***
`timescale 1ns/1ps
module sllset_lane_map
    import sllset_pkg::*;
(
    input  wire logic [LANES-1:0]   physLanes,
    input  wire logic [2:0]         selIdx,
    input  wire logic               invert,
    output logic                    logLane
);
    always_comb begin
        logLane = physLanes[selIdx] ^ invert; // RL5 RL7
    end
endmodule : sllset_lane_map

// *** hw/sllset_sync_fsm.sv ***
`timescale 1ns/1ps
module sllset_sync_fsm
    import sllset_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic syncEnable,
    input  wire logic syncArm,
    input  wire logic sysrefEdge,
    output logic      syncLocked
);
    sllset_sync_t state_r;
    logic [2:0]   alignCnt_r;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= SYNC_IDLE;
            alignCnt_r <= 3'h0;
        end else if (!syncEnable) begin
            state_r    <= SYNC_IDLE;
            alignCnt_r <= 3'h0;
        end else begin
            case (state_r)
                SYNC_IDLE: begin
                    if (syncArm) begin
                        state_r <= SYNC_ARMED;
                    end
                end
                SYNC_ARMED: begin
                    if (sysrefEdge) begin // RL2
                        state_r    <= SYNC_ALIGN;
                        alignCnt_r <= 3'h0;
                    end
                end
                SYNC_ALIGN: begin
                    if (alignCnt_r == 3'(ALIGN_CYC - 1)) begin
                        state_r <= SYNC_LOCKED;
                    end else begin
                        alignCnt_r <= alignCnt_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= SYNC_LOCKED;
                end
            endcase
        end
    end

    assign syncLocked = (state_r == SYNC_LOCKED); // RL3

    sync_lock_cause_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
        $rose(syncLocked) |-> $past(state_r) == SYNC_ALIGN)
        else $error("Sync lock without alignment.");
endmodule : sllset_sync_fsm

// *** bench/sllset_tx_model.sv ***
`timescale 1ns/1ps
module sllset_tx_model (
    input  wire logic       core_clk,
    input  wire logic       fireSysref,
    input  wire logic [7:0] laneData,
    output logic            sysrefPin,
    output logic [7:0]      physLanesPin,
    output logic [1:0]      linkSyncedPin
);
    logic [2:0] pulseCnt = 3'h0;
    logic       fired    = 1'b0;

    // One SYSREF pulse of four cycles is sent once the sync machine is armed.
    always @(negedge core_clk) begin
        if (fireSysref && !fired) begin
            fired    <= 1'b1;
            pulseCnt <= 3'h4;
        end else if (pulseCnt != 3'h0) begin
            pulseCnt <= pulseCnt - 3'h1;
        end
    end

    assign sysrefPin     = (pulseCnt != 3'h0);
    // Lane data is passed straight through from laneData, with no link setup applied.
    assign physLanesPin  = laneData;
    assign linkSyncedPin = {1'b0, fired};
endmodule : sllset_tx_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import sllset_pkg::*;

    logic        core_clk   = 1'b0;
    logic        nrst       = 1'b0;
    sllset_req_t hostReq    = '0;
    sllset_rsp_t hostRsp;
    logic        pllEnable  = 1'b0;
    logic        fireSysref = 1'b0;
    logic [7:0]  laneData   = 8'h00;
    logic        sysrefPin;
    logic [7:0]  physLanesPin;
    logic [1:0]  linkSyncedPin;
    logic [7:0]  logLanes;
    logic [1:0]  linkEnables;
    logic        syncLockedOut;
    logic        pllLockedOut;
    logic [7:0]  xbarRst [4] = '{RST_XBAR0, RST_XBAR1, RST_XBAR2, RST_XBAR3};
    int          num_errors = 0;
    int          cmp_count  = 0;

    always #2.5 core_clk = ~core_clk;

    sllset_tx_model u_tx (
        .core_clk      (core_clk),
        .fireSysref    (fireSysref),
        .laneData      (laneData),
        .sysrefPin     (sysrefPin),
        .physLanesPin  (physLanesPin),
        .linkSyncedPin (linkSyncedPin)
    );

    sllset_link_setup u_dut (
        .core_clk      (core_clk),
        .nrst          (nrst),
        .hostReq       (hostReq),
        .hostRsp       (hostRsp),
        .pllEnable     (pllEnable),
        .sysrefPin     (sysrefPin),
        .physLanesPin  (physLanesPin),
        .linkSyncedPin (linkSyncedPin),
        .logLanes      (logLanes),
        .linkEnables   (linkEnables),
        .syncLockedOut (syncLockedOut),
        .pllLockedOut  (pllLockedOut)
    );

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic timed_out(input string what);
        num_errors++;
        $display("wrong value at %0t: %s never came", $time, what);
        complete_run();
    endtask : timed_out

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        hostReq = '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        hostReq = '0;
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] msk);
        int i;
        @(negedge core_clk);
        hostReq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        hostReq = '0;
        for (i = 0; i < 4 && hostRsp.valid !== 1'b1; i++) @(negedge core_clk);
        if (hostRsp.valid !== 1'b1) timed_out("read answer");
        chk(hostRsp.rdata & msk, exp, $sformatf("reg %h", a));
    endtask : rchk

    task automatic wait_high(input bit pickSync, input int lim, input string what);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((pickSync ? syncLockedOut : pllLockedOut) === 1'b1) break;
            @(negedge core_clk);
        end
        if ((pickSync ? syncLockedOut : pllLockedOut) !== 1'b1) timed_out(what);
    endtask : wait_high

    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) rchk(OFF_XBAR_FIRST + 12'(i), xbarRst[i], 8'hff);
        rchk(OFF_LINK_CTRL, 8'h00, 8'hff);
        rchk(12'h123, 8'h00, 8'hff);
        wr(OFF_SYNC_STAT, 8'hff);
        rchk(OFF_SYNC_STAT, 8'h00, 8'hff);
        $display("test reset values done");

        pllEnable = 1'b1;
        repeat (100) @(negedge core_clk);
        rchk(OFF_PLL_STAT, 8'h00, 8'h01);
        wait_high(1'b0, 400, "pll lock");
        rchk(OFF_PLL_STAT, 8'h01, 8'h01);
        $display("test pll lock done");

        wr(OFF_SYNC_CTRL, 8'h01);
        wr(OFF_SYNC_CTRL, 8'h81);
        wr(OFF_SYNC_CTRL, 8'hc1);
        rchk(OFF_SYNC_CTRL, 8'hc1, 8'hff);
        rchk(OFF_SYNC_STAT, 8'h00, 8'h08);
        fireSysref = 1'b1;
        wait_high(1'b1, 20, "sync lock");
        rchk(OFF_SYNC_STAT, 8'h08, 8'h08);
        wr(OFF_SYNC_CTRL, 8'h01);
        rchk(OFF_SYNC_STAT, 8'h00, 8'h08);
        $display("test sync machine done");

        wr(OFF_LINK_CTRL, 8'h0b);
        chk({6'h00, linkEnables}, {6'h00, LINK_EN_DUAL}, "dual enables");
        wr(OFF_LINK_CTRL, 8'h01);
        chk({6'h00, linkEnables}, {6'h00, LINK_EN_SINGLE}, "single enables");
        wr(OFF_LINK_CTRL, 8'h03);
        chk({6'h00, linkEnables}, 8'h00, "mismatched enables");
        wr(OFF_MFDEL0, 8'h11);
        wr(OFF_MFDEL1, 8'h22);
        wr(OFF_MFVAR0, 8'h33);
        wr(OFF_MFVAR1, 8'h44);
        wr(OFF_LINK_CTRL, 8'h01);
        rchk(OFF_MFDEL0, 8'h11, 8'hff);
        rchk(OFF_MFVAR0, 8'h33, 8'hff);
        wr(OFF_LINK_CTRL, 8'h05);
        rchk(OFF_MFDEL0, 8'h22, 8'hff);
        rchk(OFF_MFVAR0, 8'h44, 8'hff);
        rchk(OFF_MFDEL1, 8'h22, 8'hff);
        rchk(OFF_MFVAR1, 8'h44, 8'hff);
        wr(OFF_SUBCLASS, 8'h01);
        rchk(OFF_SUBCLASS, 8'h01, 8'hff);
        rchk(OFF_LINK_CTRL, 8'h05, 8'hff);
        $display("test link control done");

        laneData = 8'ha5;
        repeat (5) @(negedge core_clk);
        chk(logLanes, 8'ha5, "identity lanes");
        wr(OFF_POL_INV, 8'h0f);
        repeat (4) @(negedge core_clk);
        chk(logLanes, 8'haa, "inverted lanes");
        rchk(OFF_POL_INV, 8'h0f, 8'hff);
        wr(OFF_XBAR_FIRST, 8'h01);
        repeat (4) @(negedge core_clk);
        chk(logLanes, 8'ha9, "swapped lanes");
        $display("test lanes done");
        complete_run();
    end
endmodule : tb_top
